// ==== rtl/fbe_pkg.sv ====
// Package for the flash block erase sequencer: register offsets, fields, timing.
// Assumes a single 50 MHz clock and a plain strobe register port from the core.
package fbe_pkg;

  // ==========================================================================
  // Register map
  localparam logic [1:0] ADDR_PTR_LO = 2'h0;
  localparam logic [1:0] ADDR_PTR_HI = 2'h1;
  localparam logic [1:0] ADDR_CTRL = 2'h2;
  localparam logic [1:0] ADDR_UNLOCK = 2'h3;

  // ==========================================================================
  // Control register fields
  localparam int CTRL_WR_BIT = 1;
  localparam int CTRL_WRITE_ENABLE_BIT_BIT = 2;
  localparam int CTRL_ERASE_BIT = 4;
  localparam int CTRL_ERR_BIT = 3;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] CTRL_WMASK = 8'h14;

  // ==========================================================================
  // Unlock keys and addressing
  localparam logic [7:0] UNLOCK_KEY1 = 8'h55;
  localparam logic [7:0] UNLOCK_KEY2 = 8'hAA;
  localparam int PTR_W = 22;
  localparam int BLK_LSB = 10;
  localparam int BLK_W = 12;
  localparam int BLOCK_WORDS = 256;
  localparam int BLOCK_BYTES = 512;

  // ==========================================================================
  // Erase timing
  localparam int CLK_MHZ = 50;
  localparam int ERASE_TIME_US = 1000;
  localparam int ERASE_CYCLES = ERASE_TIME_US * CLK_MHZ;
  localparam int CNT_W = 24;

  // ==========================================================================
  // Types
  typedef enum logic [1:0] {
    UL_IDLE = 2'b00,
    UL_KEY1 = 2'b01,
    UL_OPEN = 2'b10
  } fbe_unlock_t;

  typedef struct packed {
    logic [1:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } fbe_bus_t;

  typedef struct packed {
    logic req;
    logic [BLK_W-1:0] block;
  } fbe_erase_t;

endpackage

// ==== rtl/fbe_sequencer.sv ====
// Flash block erase sequencer: unlock check, erase launch, core stall, timer.
// Assumes the core drives a one-cycle strobe register port on the same clock.
//
// Decided for this implementation: the placing of the registers and the strobed register port.
module fbe_sequencer #(
  parameter int ERASE_CYCLES_P = fbe_pkg::ERASE_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register port
  input wire logic [1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Flash array and core
  output fbe_pkg::fbe_erase_t erase_cmd,
  output logic erase_busy,
  output logic core_stall
);

  // ==========================================================================
  // Bus decode
  fbe_pkg::fbe_bus_t bus;
  assign bus = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

  logic [fbe_pkg::PTR_W-1:0] ptr_r;
  logic [7:0] ctrl_r;
  logic err_r;
  fbe_pkg::fbe_unlock_t unlock_r;
  logic busy_r;
  logic [fbe_pkg::CNT_W-1:0] cnt_r;
  logic done;
  logic start;
  logic wr_ctrl;
  logic wr_unlock;

  assign wr_ctrl = bus.wr && (bus.addr == fbe_pkg::ADDR_CTRL);
  assign wr_unlock = bus.wr && (bus.addr == fbe_pkg::ADDR_UNLOCK);
  assign done = busy_r && (cnt_r == '0);
  // Initiate is honoured only with write enable, erase select and open lock.
  assign start = wr_ctrl && bus.wdata[fbe_pkg::CTRL_WR_BIT] && !busy_r
    && ctrl_r[fbe_pkg::CTRL_WRITE_ENABLE_BIT_BIT] && bus.wdata[fbe_pkg::CTRL_WRITE_ENABLE_BIT_BIT]
    && bus.wdata[fbe_pkg::CTRL_ERASE_BIT]
    && (unlock_r == fbe_pkg::UL_OPEN);

  // ==========================================================================
  // Address pointer
  always_ff @(posedge clk) begin
    if (rst) begin
      ptr_r <= '0;
    end else if (bus.wr && !busy_r && bus.addr == fbe_pkg::ADDR_PTR_LO) begin
      ptr_r[7:0] <= bus.wdata;
    end else if (bus.wr && !busy_r && bus.addr == fbe_pkg::ADDR_PTR_HI) begin
      // Only bits 15:0 are reachable over the port; bits 21:16 stay zero.
      ptr_r[15:8] <= bus.wdata;
    end
  end

  // ==========================================================================
  // Unlock sequence
  always_ff @(posedge clk) begin
    if (rst) begin
      unlock_r <= fbe_pkg::UL_IDLE;
    end else if (done || start) begin
      unlock_r <= fbe_pkg::UL_IDLE;
    end else if (wr_unlock) begin
      unique case (unlock_r)
        fbe_pkg::UL_IDLE: begin
          unlock_r <= (bus.wdata == fbe_pkg::UNLOCK_KEY1) ? fbe_pkg::UL_KEY1
            : fbe_pkg::UL_IDLE;
        end
        fbe_pkg::UL_KEY1: begin
          unlock_r <= (bus.wdata == fbe_pkg::UNLOCK_KEY2) ? fbe_pkg::UL_OPEN
            : fbe_pkg::UL_IDLE;
        end
        fbe_pkg::UL_OPEN: begin
          unlock_r <= fbe_pkg::UL_IDLE;
        end
        default: begin
          unlock_r <= fbe_pkg::UL_IDLE;
        end
      endcase
    end else if (wr_ctrl) begin
      unlock_r <= fbe_pkg::UL_IDLE;
    end
  end

  // ==========================================================================
  // Control register
  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_r <= fbe_pkg::CTRL_RESET;
    end else if (done) begin
      ctrl_r[fbe_pkg::CTRL_WR_BIT] <= 1'b0;
    end else if (wr_ctrl && !busy_r) begin
      ctrl_r <= bus.wdata & fbe_pkg::CTRL_WMASK;
      ctrl_r[fbe_pkg::CTRL_WR_BIT] <= start;
    end
  end

  // Refused initiate is flagged; cleared by a control write without initiate.
  always_ff @(posedge clk) begin
    if (rst) begin
      err_r <= 1'b0;
    end else if (wr_ctrl && !busy_r) begin
      err_r <= bus.wdata[fbe_pkg::CTRL_WR_BIT] && !start;
    end
  end

  // ==========================================================================
  // Erase timer
  always_ff @(posedge clk) begin
    if (rst) begin
      busy_r <= 1'b0;
      cnt_r <= '0;
    end else if (start) begin
      busy_r <= 1'b1;
      cnt_r <= fbe_pkg::CNT_W'(ERASE_CYCLES_P - 1);
    end else if (done) begin
      busy_r <= 1'b0;
    end else if (busy_r) begin
      cnt_r <= cnt_r - 1'b1;
    end
  end

  // ==========================================================================
  // Outputs
  always_ff @(posedge clk) begin
    if (rst) begin
      erase_cmd <= '0;
    end else begin
      erase_cmd.req <= start;
      if (start) begin
        erase_cmd.block <= ptr_r[fbe_pkg::BLK_LSB +: fbe_pkg::BLK_W];
      end
    end
  end

  assign erase_busy = busy_r;
  assign core_stall = busy_r;

  always_ff @(posedge clk) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (bus.rd) begin
      unique case (bus.addr)
        fbe_pkg::ADDR_PTR_LO: reg_rdata <= ptr_r[7:0];
        fbe_pkg::ADDR_PTR_HI: reg_rdata <= ptr_r[15:8];
        fbe_pkg::ADDR_CTRL: begin
          reg_rdata <= ctrl_r;
          reg_rdata[fbe_pkg::CTRL_ERR_BIT] <= err_r;
        end
        fbe_pkg::ADDR_UNLOCK: reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // ==========================================================================
  // Assertion helper: cycles spent stalled in the current erase.
  logic [fbe_pkg::CNT_W-1:0] stall_len_r;

  always_ff @(posedge clk) begin
    if (rst) begin
      stall_len_r <= '0;
    end else if (busy_r) begin
      stall_len_r <= stall_len_r + 1'b1;
    end else begin
      stall_len_r <= '0;
    end
  end

  // ==========================================================================
  // Assertions
  sequence s_key1;
    unlock_r == fbe_pkg::UL_IDLE && wr_unlock && bus.wdata == fbe_pkg::UNLOCK_KEY1
      && !busy_r;
  endsequence

  sequence s_key2;
    wr_unlock && bus.wdata == fbe_pkg::UNLOCK_KEY2 && !busy_r;
  endsequence

  sequence s_unlock;
    s_key1 ##1 s_key2;
  endsequence

  AST_NO_START_WITHOUT_WRITE_ENABLE_BIT: assert property (@(posedge clk) disable iff (rst)
    (wr_ctrl && !busy_r && !bus.wdata[fbe_pkg::CTRL_WRITE_ENABLE_BIT_BIT]) |=> !busy_r)
    else $error("Erase started without write enable.");

  AST_REFUSE_FLAG: assert property (@(posedge clk) disable iff (rst)
    (wr_ctrl && !busy_r && bus.wdata[fbe_pkg::CTRL_WR_BIT] && !start) |=> err_r)
    else $error("Refused initiate not flagged.");

  AST_NEEDS_ERASE_SEL: assert property (@(posedge clk) disable iff (rst)
    (wr_ctrl && !bus.wdata[fbe_pkg::CTRL_ERASE_BIT]) |=> !erase_cmd.req)
    else $error("Long cycle started without erase select.");

  AST_KEY_ORDER: assert property (@(posedge clk) disable iff (rst)
    (unlock_r == fbe_pkg::UL_IDLE && wr_unlock && bus.wdata == fbe_pkg::UNLOCK_KEY2
      && !busy_r) |=> unlock_r == fbe_pkg::UL_IDLE)
    else $error("Reversed keys advanced the unlock.");

  AST_UNLOCK_READS_ZERO: assert property (@(posedge clk) disable iff (rst)
    (bus.rd && bus.addr == fbe_pkg::ADDR_UNLOCK) |=> reg_rdata == 8'h00)
    else $error("Unlock register read back nonzero.");

  AST_REQ_PULSE: assert property (@(posedge clk) disable iff (rst)
    erase_cmd.req |=> !erase_cmd.req)
    else $error("Erase request longer than one cycle.");

  AST_REQ_FROM_START: assert property (@(posedge clk) disable iff (rst)
    erase_cmd.req |-> $past(start))
    else $error("Erase request without accepted initiate.");

  AST_PTR_FROZEN: assert property (@(posedge clk) disable iff (rst)
    busy_r |=> $stable(ptr_r))
    else $error("Pointer changed during erase.");

  AST_CTRL_FROZEN: assert property (@(posedge clk) disable iff (rst)
    (busy_r && !done) |=> $stable(ctrl_r))
    else $error("Control changed during erase.");

  AST_TIMER_LOAD: assert property (@(posedge clk) disable iff (rst)
    start |=> cnt_r == fbe_pkg::CNT_W'(ERASE_CYCLES_P - 1))
    else $error("Erase timer not loaded at start.");

  AST_TIMER_DOWN: assert property (@(posedge clk) disable iff (rst)
    (busy_r && !done) |=> cnt_r == $past(cnt_r) - 1'b1)
    else $error("Erase timer did not count down.");

  AST_STALL_TOTAL: assert property (@(posedge clk) disable iff (rst)
    $fell(busy_r) |-> stall_len_r == fbe_pkg::CNT_W'(ERASE_CYCLES_P))
    else $error("Stall length differs from erase time.");

  AST_DONE_RELEASES: assert property (@(posedge clk) disable iff (rst)
    done |=> !core_stall)
    else $error("Stall not released at completion.");

  AST_START_NEEDS_UNLOCK: assert property (@(posedge clk) disable iff (rst)
    (!busy_r ##1 busy_r) |-> $past(unlock_r == fbe_pkg::UL_OPEN))
    else $error("Erase started without unlock.");

  AST_UNLOCK_OPENS: assert property (@(posedge clk) disable iff (rst)
    s_unlock |=> unlock_r == fbe_pkg::UL_OPEN)
    else $error("Unlock sequence did not open.");

  AST_START_ERASE: assert property (@(posedge clk) disable iff (rst)
    start |=> busy_r && erase_cmd.req && ctrl_r[fbe_pkg::CTRL_WR_BIT])
    else $error("Valid initiate did not start erase.");

  AST_BLOCK_SEL: assert property (@(posedge clk) disable iff (rst)
    start |=> erase_cmd.block == $past(ptr_r[21:10]))
    else $error("Wrong block selected.");

  AST_STALL: assert property (@(posedge clk) disable iff (rst)
    (busy_r && !done) |=> core_stall)
    else $error("Core not stalled during erase.");

  AST_STALL_LEN: assert property (@(posedge clk) disable iff (rst)
    (busy_r && cnt_r == fbe_pkg::CNT_W'(2)) |=> busy_r ##1 busy_r ##1 !core_stall)
    else $error("Stall did not end on timer.");

  AST_DONE_CLEARS: assert property (@(posedge clk) disable iff (rst)
    done |=> !ctrl_r[fbe_pkg::CTRL_WR_BIT] && unlock_r == fbe_pkg::UL_IDLE)
    else $error("Completion left initiate or unlock set.");

endmodule

// ==== sim/fbe_core_model.sv ====
// Core model: firmware register reads and writes toward the sequencer.
// Assumes read data stand only in the cycle after the read strobe.
module fbe_core_model (
  // Clock and answers
  input wire logic clk,
  input wire logic core_stall,
  input wire logic [7:0] reg_rdata,
  // Register port
  output fbe_pkg::fbe_bus_t bus
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========
  // Bus cycles: a stalled core issues nothing; idle address and data lines show inverted values, strobes low.
  initial bus = '0;
  task automatic cyc(input logic [1:0] a, input logic [7:0] d, input logic w);
    while (core_stall) @(posedge clk);
    bus <= '{a, d, w, !w};
    @(posedge clk);
    bus <= '{~a, ~d, 1'b0, 1'b0};
    @(posedge clk);
  endtask
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    cyc(a, d, 1'b1);
  endtask
  task automatic rd(input logic [1:0] a, output logic [7:0] d);
    cyc(a, 8'h00, 1'b0);
    d = reg_rdata;
  endtask
endmodule

// ==== sim/tb_flash_block_erase_sequencer.sv ====
// Testbench of the flash block erase sequencer driven by a core model.
// Assumes the erase count is shortened to eight cycles.
module tb_flash_block_erase_sequencer;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========
  // Signals and design
  localparam int ERASE_N = 8;
  typedef struct packed {
    logic [21:0] ptr;
    logic [7:0] c0;
    logic [7:0] k1;
    logic [7:0] k2;
    logic go;
  } fbe_row_t;
  fbe_row_t rows [7] = '{
    '{22'h003FFF, 8'h14, 8'h55, 8'hAA, 1'b1},
    '{22'h000400, 8'h14, 8'h55, 8'hAA, 1'b1},
    '{22'h0027FF, 8'h14, 8'h55, 8'hAA, 1'b1},
    '{22'h001800, 8'h14, 8'h55, 8'hAA, 1'b1},
    '{22'h000123, 8'h14, 8'hAA, 8'h55, 1'b0},
    '{22'h000800, 8'h10, 8'h55, 8'hAA, 1'b0},
    '{22'h000800, 8'h14, 8'h55, 8'h56, 1'b0}};
  logic clk;
  logic rst;
  logic [7:0] rdata;
  logic [7:0] rv;
  fbe_pkg::fbe_bus_t bus;
  fbe_pkg::fbe_erase_t cmd;
  logic busy;
  logic stall;
  logic [11:0] req_cnt;
  logic [11:0] busy_cnt;
  logic [11:0] blk;
  int miscompares = 0;
  int tests_run = 0;
  fbe_sequencer #(.ERASE_CYCLES_P(ERASE_N)) dut_u (.clk(clk), .rst(rst), .reg_addr(bus.addr),
    .reg_wdata(bus.wdata), .reg_wr(bus.wr), .reg_rd(bus.rd), .reg_rdata(rdata),
    .erase_cmd(cmd), .erase_busy(busy), .core_stall(stall));
  fbe_core_model core_u (.clk(clk), .core_stall(stall), .reg_rdata(rdata), .bus(bus));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // ==========
  // Tasks
  task automatic check(input string nm, input logic [11:0] seen, input logic [11:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic do_reset();
    rst <= 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
  endtask
  task automatic erase(input logic [21:0] p, input logic [7:0] c0, k1, k2);
    core_u.wr(fbe_pkg::ADDR_PTR_LO, p[7:0]);
    core_u.wr(fbe_pkg::ADDR_PTR_HI, p[15:8]);
    core_u.wr(fbe_pkg::ADDR_CTRL, c0);
    core_u.wr(fbe_pkg::ADDR_UNLOCK, k1);
    core_u.wr(fbe_pkg::ADDR_UNLOCK, k2);
    core_u.wr(fbe_pkg::ADDR_CTRL, 8'h16);
    core_u.rd(fbe_pkg::ADDR_CTRL, rv);
  endtask
  // ==========
  // Monitor of erase pulses, busy cycles, block and stall.
  always @(posedge clk) begin
    if (rst) begin
      req_cnt <= 12'h000;
      busy_cnt <= 12'h000;
    end else begin
      req_cnt <= req_cnt + 12'(cmd.req);
      busy_cnt <= busy_cnt + 12'(busy);
      if (cmd.req) blk <= cmd.block;
      if (stall !== busy) check("stall", {11'h000, stall}, {11'h000, busy});
    end
  end
  // ==========
  // Main sequence
  initial begin
    rst = 1'b1;
    do_reset();
    core_u.rd(fbe_pkg::ADDR_CTRL, rv);
    check("ctrl_rst", {4'h0, rv}, {4'h0, fbe_pkg::CTRL_RESET});
    core_u.rd(fbe_pkg::ADDR_UNLOCK, rv);
    check("unlock_rd", {4'h0, rv}, 12'h000);
    check("busy_rst", {10'h000, busy, stall}, 12'h000);
    $display("reset test done");
    for (int i = 0; i < 7; i++) begin
      do_reset();
      erase(rows[i].ptr, rows[i].c0, rows[i].k1, rows[i].k2);
      check("req", req_cnt, {11'h000, rows[i].go});
      check("busy_len", busy_cnt, rows[i].go ? 12'(ERASE_N) : 12'h000);
      if (rows[i].go) check("block", blk, rows[i].ptr[21:10]);
      check("ctrl", {11'h000, rows[i].go ? rv[1] : rv[3]}, {11'h000, !rows[i].go});
      $display("row %0d done", i);
    end
    do_reset();
    erase(22'h000C00, 8'h14, 8'h55, 8'hAA);
    core_u.wr(fbe_pkg::ADDR_CTRL, 8'h16);
    core_u.rd(fbe_pkg::ADDR_CTRL, rv);
    check("relock", req_cnt, 12'h001);
    core_u.wr(fbe_pkg::ADDR_UNLOCK, 8'h55);
    core_u.wr(fbe_pkg::ADDR_UNLOCK, 8'hAA);
    core_u.wr(fbe_pkg::ADDR_CTRL, 8'h16);
    @(negedge clk);
    check("reunlock", req_cnt, 12'h002);
    do_reset();
    check("abort", {10'h000, busy, stall}, 12'h000);
    $display("hand tests done");
    finish_test();
  end
  initial begin
    #100000;
    miscompares++;
    finish_test();
  end
endmodule
